// *** rtl/fracn_pll_ctrl.sv ***
`timescale 1ns/10ps
`include "pll_ctrl_defines.svh"


module fracn_pll_ctrl
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // reference and feedback pins
  input  wire logic                ref_in,
  input  wire logic                rf_in,
  // serial configuration pins
  input  wire logic                ser_clk,
  input  wire logic                ser_data,
  input  wire logic                ser_load,
  // register port
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [`DATA_W-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [`DATA_W-1:0]       reg_rdata_q,
  // reference input switches
  output logic                     ref_series_a_q,
  output logic                     ref_series_b_q,
  output logic                     ref_shunt_q,
  // phase detector and charge pump
  output logic                     pump_out_pos_q,
  output logic                     pump_out_neg_q,
  output logic [`CELLS-1:0]        pump_cells_en,
  // loop filter switches and lock
  output logic                     filter_switch_a,
  output logic                     filter_switch_b,
  output logic                     filter_switch_c,
  output logic                     lock_detect_q
);

  localparam int NPIN = 5;
  localparam int P_REF = 0;
  localparam int P_RF = 1;
  localparam int P_SCK = 2;
  localparam int P_SDA = 3;
  localparam int P_SLD = 4;

  logic [NPIN-1:0]      s1_q, s2_q, s3_q, lvl_q;
  logic [NPIN-1:0]      rise_q, fall_q, lvl_d;
  logic [`CFG_W-1:0]    cfg_q [`NUM_CFG];
  logic [`CFG_W-1:0]    shift_q;
  logic [`TMR_W-1:0]    t_pump_q, t_ab_q, t_c_q;
  logic                 wr_hit, ld_hit, new_freq;
  logic [`IDX_W-1:0]    wr_idx;
  logic [`CFG_W-1:0]    wr_word;
  logic                 power_down, ref_ev;
  logic [`RDIV_W-1:0]   rdiv, rcnt_q;
  logic                 pfd_ref_q, pfd_rise_q, pfd_fall_q, pfd_prev_q;
  logic [1:0]           tick_cnt_q;
  logic                 tick_q;
  logic                 fb_pulse;
  logic                 up_d, dn_d, pair_done;
  logic [7:0]           err_cnt_q;
  logic [5:0]           good_cnt_q;
  logic                 sw_ab, sw_c;
  lock_phase_t          phase;

  // two-flop filter: a change counts once stages two and three agree
  always_comb begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
  end

  // pin synchronisers and edge pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q   <= {ser_load, ser_data, ser_clk, rf_in, ref_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
      fall_q <= ~lvl_d & lvl_q;
    end
  end

  // serial shift register, MSB first on serial clock rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else if (rise_q[P_SCK]) begin
      shift_q <= {shift_q[`CFG_W-2:0], lvl_q[P_SDA]};
    end
  end

  // word source: load rise or register port write
  always_comb begin
    ld_hit  = rise_q[P_SLD];
    wr_hit  = reg_wr && (reg_addr < `ADDR_W'(`NUM_CFG));
    wr_idx  = ld_hit ? shift_q[`IDX_LSB +: `IDX_W]
                     : reg_addr[`IDX_W-1:0];
    wr_word = ld_hit ? shift_q : reg_wdata[`CFG_W-1:0];
    new_freq = (ld_hit || wr_hit) && wr_idx == `IDX_FREQ;
  end

  // configuration words
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `NUM_CFG; i++) begin
        cfg_q[i] <= '0;
      end
    end else if (ld_hit || wr_hit) begin
      cfg_q[wr_idx] <= wr_word;
    end
  end

  // timeout values, one per timer select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_pump_q <= '0;
      t_ab_q   <= '0;
      t_c_q    <= '0;
    end else if ((ld_hit || wr_hit) && wr_idx == `IDX_PUMP) begin
      case (wr_word[`TSEL_LSB +: `TSEL_W])
        `TSEL_PUMP: t_pump_q <= wr_word[`TMR_LSB +: `TMR_W];
        `TSEL_AB:   t_ab_q   <= wr_word[`TMR_LSB +: `TMR_W];
        `TSEL_C:    t_c_q    <= wr_word[`TMR_LSB +: `TMR_W];
        default:    t_pump_q <= t_pump_q;
      endcase
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      if (reg_addr < `ADDR_W'(`NUM_CFG)) begin
        reg_rdata_q <= `DATA_W'(cfg_q[reg_addr[`IDX_W-1:0]]);
      end else if (reg_addr == `ADDR_STATUS) begin
        reg_rdata_q <= `DATA_W'({phase, sw_c, sw_ab, ref_shunt_q,
                                 pump_out_neg_q, pump_out_pos_q,
                                 lock_detect_q});
      end else begin
        reg_rdata_q <= '0;
      end
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // reference switches follow power-down
  assign power_down = cfg_q[`IDX_PWR][`PWR_DOWN_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_series_a_q <= 1'b1;
      ref_series_b_q <= 1'b1;
      ref_shunt_q    <= 1'b0;
    end else begin
      ref_series_a_q <= ~power_down;
      ref_series_b_q <= ~power_down;
      ref_shunt_q    <= power_down;
    end
  end

  // reference events: falling edge, both edges when doubled
  always_comb begin
    ref_ev = fall_q[P_REF] ||
             (cfg_q[`IDX_MODR][`DBL_BIT] && rise_q[P_REF]);
    rdiv   = cfg_q[`IDX_MODR][`RDIV_LSB +: `RDIV_W];
  end

  // reference divider and optional toggle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q    <= '0;
      pfd_ref_q <= 1'b0;
    end else if (power_down) begin
      rcnt_q    <= '0;
      pfd_ref_q <= 1'b0;
    end else if (ref_ev) begin
      if (rcnt_q + `RDIV_W'(1) >= rdiv) begin
        rcnt_q <= '0;
        if (cfg_q[`IDX_MODR][`HALF_BIT]) begin
          pfd_ref_q <= ~pfd_ref_q;
        end else begin
          pfd_ref_q <= 1'b1;
        end
      end else begin
        rcnt_q <= rcnt_q + `RDIV_W'(1);
        if (!cfg_q[`IDX_MODR][`HALF_BIT]) pfd_ref_q <= 1'b0;
      end
    end
  end

  // PFD reference edges and quarter-rate timer tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfd_prev_q <= 1'b0;
      pfd_rise_q <= 1'b0;
      pfd_fall_q <= 1'b0;
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      pfd_prev_q <= pfd_ref_q;
      pfd_rise_q <= pfd_ref_q & ~pfd_prev_q;
      pfd_fall_q <= ~pfd_ref_q & pfd_prev_q;
      tick_q     <= 1'b0;
      if (pfd_fall_q) begin
        tick_cnt_q <= tick_cnt_q + 2'h1;
        if (tick_cnt_q == 2'(`TICK_DIV - 1)) tick_q <= 1'b1;
      end
    end
  end

  // feedback divider with modulator
  fb_divider u_fb (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .rf_edge       (rise_q[P_RF]),
    .int_word      (cfg_q[`IDX_FREQ][`INT_LSB +: `INT_W]),
    .fraction_word (cfg_q[`IDX_FREQ][`FRACTION_WORD_LSB +: `FRACTION_WORD_W]),
    .modulus_word  (cfg_q[`IDX_MODR][`MOD_LSB +: `MOD_W]),
    .pre_89        (cfg_q[`IDX_MODR][`PRE_BIT]),
    .fb_pulse_q    (fb_pulse)
  );

  // phase detector: set on each edge, clear when both are up
  always_comb begin
    up_d      = pump_out_pos_q | pfd_rise_q;
    dn_d      = pump_out_neg_q | fb_pulse;
    pair_done = up_d & dn_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_out_pos_q <= 1'b0;
      pump_out_neg_q <= 1'b0;
    end else if (power_down || pair_done) begin
      pump_out_pos_q <= 1'b0;
      pump_out_neg_q <= 1'b0;
    end else begin
      pump_out_pos_q <= up_d;
      pump_out_neg_q <= dn_d;
    end
  end

  // lock indicator from phase error width
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_q     <= '0;
      good_cnt_q    <= '0;
      lock_detect_q <= 1'b0;
    end else if (new_freq) begin
      err_cnt_q     <= '0;
      good_cnt_q    <= '0;
      lock_detect_q <= 1'b0;
    end else if (pair_done) begin
      err_cnt_q <= '0;
      if (err_cnt_q < 8'(`LOCK_FINE_CYC)) begin
        if (good_cnt_q == 6'(`LOCK_GOOD_COUNT - 1)) begin
          lock_detect_q <= 1'b1;
        end else begin
          good_cnt_q <= good_cnt_q + 6'h1;
        end
      end else begin
        good_cnt_q <= '0;
        if (err_cnt_q > 8'(`LOCK_COARSE_CYC)) lock_detect_q <= 1'b0;
      end
    end else if ((up_d ^ dn_d) && err_cnt_q != 8'hff) begin
      err_cnt_q <= err_cnt_q + 8'h01;
    end
  end

  // fast-lock timers, cell selection and switches
  fastlock_timers u_tmr (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .tick               (tick_q),
    .restart            (new_freq),
    .pump_current_timer (t_pump_q),
    .switch_ab_timer    (t_ab_q),
    .switch_c_timer     (t_c_q),
    .cells_en_q         (pump_cells_en),
    .filter_switch_ab_q (sw_ab),
    .filter_switch_c_q  (sw_c),
    .phase_q            (phase)
  );

  assign filter_switch_a = sw_ab;
  assign filter_switch_b = sw_ab;
  assign filter_switch_c = sw_c;

endmodule : fracn_pll_ctrl

// *** shared/pll_ctrl_defines.svh ***
`ifndef PLL_CTRL_DEFINES_SVH
`define PLL_CTRL_DEFINES_SVH

// configuration word indices, selected by the low three word bits
`define IDX_LSB          0
`define IDX_W            3
`define IDX_FREQ         3'h0
`define IDX_MODR         3'h1
`define IDX_PUMP         3'h4
`define IDX_PWR          3'h5
`define CFG_W            24
`define NUM_CFG          8

// frequency word fields
`define INT_LSB          15
`define INT_W            9
`define FRACTION_WORD_LSB         3
`define FRACTION_WORD_W           12
// modulus / reference word fields
`define MOD_LSB          3
`define MOD_W            12
`define RDIV_LSB         15
`define RDIV_W           4
`define DBL_BIT          19
`define PRE_BIT          20
`define HALF_BIT         22
// pump timer word fields
`define TMR_LSB          5
`define TMR_W            9
`define TSEL_LSB         3
`define TSEL_W           2
`define TSEL_PUMP        2'h0
`define TSEL_AB          2'h1
`define TSEL_C           2'h2
// power word fields
`define PWR_DOWN_BIT     7

// register port map
`define ADDR_W           4
`define DATA_W           32
`define ADDR_STATUS      4'h8

// fast-lock timing
`define TICK_DIV         4
`define RAMP_STEPS       6
`define CELLS            64
`define LOCK_GOOD_COUNT  40
`define CLK_PERIOD_NS    20
`define LOCK_FINE_NS     3
`define LOCK_COARSE_NS   30
`define LOCK_FINE_CYC    ((`LOCK_FINE_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
                          (`LOCK_FINE_NS / `CLK_PERIOD_NS))
`define LOCK_COARSE_CYC  ((`LOCK_COARSE_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
                          (`LOCK_COARSE_NS / `CLK_PERIOD_NS))

`endif

// *** shared/pll_ctrl_pkg.sv ***
package pll_ctrl_pkg;

  // fast-lock progress
  typedef enum logic [1:0] {
    PH_WIDE,
    PH_RAMP,
    PH_NARROW
  } lock_phase_t;

endpackage : pll_ctrl_pkg

// *** rtl/fb_divider.sv ***
`timescale 1ns/10ps
`include "pll_ctrl_defines.svh"

module fb_divider
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // feedback edges and setting
  input  wire logic                rf_edge,
  input  wire logic [`INT_W-1:0]   int_word,
  input  wire logic [`FRACTION_WORD_W-1:0]  fraction_word,
  input  wire logic [`MOD_W-1:0]   modulus_word,
  input  wire logic                pre_89,
  // divided feedback event
  output logic                     fb_pulse_q
);

  logic [`FRACTION_WORD_W-1:0] acc1_q, acc2_q, acc3_q;
  logic [`FRACTION_WORD_W:0]   s1, s2, s3;
  logic               c2_prev_q, c3_prev_q, c3_prev2_q;
  logic signed [4:0]  offset;
  logic [9:0]         n_next;
  logic [3:0]         pre_cnt_q, last;
  logic [7:0]         b_cnt_q;
  logic [3:0]         a_cnt_q;

  // modulo accumulate, carry in the top bit
  function automatic logic [`FRACTION_WORD_W:0] mod_add(
    input logic [`FRACTION_WORD_W-1:0] acc,
    input logic [`FRACTION_WORD_W-1:0] inc,
    input logic [`MOD_W-1:0]  m
  );
    logic [`FRACTION_WORD_W:0] s;
    s = {1'b0, acc} + {1'b0, inc};
    if (m != '0 && s >= {1'b0, m}) begin
      mod_add = {1'b1, s[`FRACTION_WORD_W-1:0] - m};
    end else begin
      mod_add = {1'b0, s[`FRACTION_WORD_W-1:0]};
    end
  endfunction : mod_add

  // third-order cascaded modulator stages
  always_comb begin
    s1 = mod_add(acc1_q, fraction_word, modulus_word);
    s2 = mod_add(acc2_q, s1[`FRACTION_WORD_W-1:0], modulus_word);
    s3 = mod_add(acc3_q, s2[`FRACTION_WORD_W-1:0], modulus_word);
    offset = 5'(s1[`FRACTION_WORD_W]) + 5'(s2[`FRACTION_WORD_W]) - 5'(c2_prev_q)
           + 5'(s3[`FRACTION_WORD_W]) - 5'(c3_prev_q) - 5'(c3_prev_q)
           + 5'(c3_prev2_q);
    n_next = 10'({1'b0, int_word}) + 10'(signed'(offset));
    last   = (a_cnt_q != '0) ? (pre_89 ? 4'h8 : 4'h4)
                             : (pre_89 ? 4'h7 : 4'h3);
  end

  // modulator advances once per divided cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc1_q     <= '0;
      acc2_q     <= '0;
      acc3_q     <= '0;
      c2_prev_q  <= 1'b0;
      c3_prev_q  <= 1'b0;
      c3_prev2_q <= 1'b0;
    end else if (fb_pulse_q) begin
      acc1_q     <= s1[`FRACTION_WORD_W-1:0];
      acc2_q     <= s2[`FRACTION_WORD_W-1:0];
      acc3_q     <= s3[`FRACTION_WORD_W-1:0];
      c2_prev_q  <= s2[`FRACTION_WORD_W];
      c3_prev_q  <= s3[`FRACTION_WORD_W];
      c3_prev2_q <= c3_prev_q;
    end
  end

  // dual-modulus prescaler with swallow and main counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q  <= '0;
      b_cnt_q    <= 8'h01;
      a_cnt_q    <= '0;
      fb_pulse_q <= 1'b0;
    end else begin
      fb_pulse_q <= 1'b0;
      if (rf_edge) begin
        if (pre_cnt_q == last) begin
          pre_cnt_q <= '0;
          if (b_cnt_q <= 8'h01) begin
            fb_pulse_q <= 1'b1;
            b_cnt_q    <= pre_89 ? 8'(n_next >> 3) : 8'(n_next >> 2);
            a_cnt_q    <= pre_89 ? {1'b0, n_next[2:0]}
                                 : {2'b00, n_next[1:0]};
          end else begin
            b_cnt_q <= b_cnt_q - 8'h01;
            if (a_cnt_q != '0) begin
              a_cnt_q <= a_cnt_q - 4'h1;
            end
          end
        end else begin
          pre_cnt_q <= pre_cnt_q + 4'h1;
        end
      end
    end
  end

endmodule : fb_divider

// *** rtl/fastlock_timers.sv ***
`timescale 1ns/10ps
`include "pll_ctrl_defines.svh"

module fastlock_timers
  import pll_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // timer clock and restart
  input  wire logic                tick,
  input  wire logic                restart,
  // programmed timeouts
  input  wire logic [`TMR_W-1:0]   pump_current_timer,
  input  wire logic [`TMR_W-1:0]   switch_ab_timer,
  input  wire logic [`TMR_W-1:0]   switch_c_timer,
  // cell and switch controls
  output logic [`CELLS-1:0]        cells_en_q,
  output logic                     filter_switch_ab_q,
  output logic                     filter_switch_c_q,
  output lock_phase_t              phase_q
);

  logic [`TMR_W-1:0] pump_cnt_q, ab_cnt_q, c_cnt_q;
  logic [2:0]        ramp_q;

  // timeout counters, all restart on a new frequency
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_cnt_q <= '0;
      ab_cnt_q   <= '0;
      c_cnt_q    <= '0;
    end else if (restart) begin
      pump_cnt_q <= '0;
      ab_cnt_q   <= '0;
      c_cnt_q    <= '0;
    end else if (tick) begin
      if (pump_cnt_q != pump_current_timer) pump_cnt_q <= pump_cnt_q + 1'b1;
      if (ab_cnt_q != switch_ab_timer) ab_cnt_q <= ab_cnt_q + 1'b1;
      if (c_cnt_q != switch_c_timer) c_cnt_q <= c_cnt_q + 1'b1;
    end
  end

  // switches closed while own timer runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_switch_ab_q <= 1'b0;
      filter_switch_c_q  <= 1'b0;
    end else if (restart) begin
      filter_switch_ab_q <= 1'b1;
      filter_switch_c_q  <= 1'b1;
    end else if (tick) begin
      if (ab_cnt_q == switch_ab_timer) filter_switch_ab_q <= 1'b0;
      if (c_cnt_q == switch_c_timer) filter_switch_c_q <= 1'b0;
    end
  end

  // cell ramp: once the pump timer expires, halve the active set on each tick until one cell is left
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cells_en_q <= `CELLS'(1);
      ramp_q     <= '0;
      phase_q    <= PH_NARROW;
    end else if (restart) begin
      cells_en_q <= '1;
      ramp_q     <= '0;
      phase_q    <= PH_WIDE;
    end else if (tick) begin
      case (phase_q)
        PH_WIDE: begin
          if (pump_cnt_q == pump_current_timer) phase_q <= PH_RAMP;
        end
        PH_RAMP: begin
          cells_en_q <= cells_en_q >> (`CELLS >> (ramp_q + 3'h1));
          ramp_q     <= ramp_q + 3'h1;
          if (ramp_q == 3'(`RAMP_STEPS - 1)) phase_q <= PH_NARROW;
        end
        PH_NARROW: begin
          phase_q <= PH_NARROW;
        end
        default: phase_q <= PH_NARROW;
      endcase
    end
  end

endmodule : fastlock_timers

// *** bench/vco_ref_model.sv ***
`timescale 1ns/10ps

module vco_ref_model #(
  parameter int REF_HALF = 1040
) (
  // vco half period in ns, steered by the bench
  input  wire logic [9:0] vco_half,
  // reference oscillator and vco outputs
  output logic            ref_out,
  output logic            rf_out
);
  // free-running reference, edges kept off the system clock grid
  initial begin
    ref_out = 1'b0;
    #5;
    forever #(REF_HALF) ref_out = ~ref_out;
  end

  // vco, frequency set by the bench to lead or lag the reference
  initial begin
    rf_out = 1'b0;
    #7;
    forever #(vco_half) rf_out = ~rf_out;
  end
endmodule : vco_ref_model

// *** bench/pll_ctrl_asserts.sv ***
`timescale 1ns/10ps
`include "pll_ctrl_defines.svh"

module pll_ctrl_asserts (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_n,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata_q,
  // switches, pump and lock
  input wire logic               ref_series_a_q,
  input wire logic               ref_series_b_q,
  input wire logic               ref_shunt_q,
  input wire logic [`CELLS-1:0]  pump_cells_en,
  input wire logic               filter_switch_a,
  input wire logic               filter_switch_b,
  input wire logic               filter_switch_c,
  input wire logic               lock_detect_q
);
  logic [6:0] cnt;
  logic       wr0;

  // enabled cell count and new-frequency write
  assign cnt = 7'($countones(pump_cells_en));
  assign wr0 = reg_wr && reg_addr == 4'h0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ref_switches: assert property (
    ref_shunt_q != ref_series_a_q && ref_series_b_q == ref_series_a_q)
    else $error("reference switches inconsistent");
  chk_cells_binary: assert property (
    cnt inside {7'd1, 7'd2, 7'd4, 7'd8, 7'd16, 7'd32, 7'd64})
    else $error("cell count not a binary step");
  chk_new_freq: assert property (
    wr0 |-> ##[1:3] (&pump_cells_en && filter_switch_a && filter_switch_c))
    else $error("no wide mode after new frequency");
  chk_lock_drop: assert property (
    wr0 |-> ##[1:3] !lock_detect_q)
    else $error("lock kept after new frequency");
  chk_ramp_halves: assert property (
    $changed(pump_cells_en) |-> cnt == 7'd64 || cnt * 7'd2 == $past(cnt))
    else $error("cell ramp not halving");
  chk_narrow_hold: assert property (
    $past(cnt) == 7'd1 && !$past(wr0) |-> cnt == 7'd1)
    else $error("single cell state left");
  chk_ab_pair: assert property (
    filter_switch_a == filter_switch_b)
    else $error("switch a and b differ");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_q == '0)
    else $error("read data outside read slot");
  chk_unmapped_read: assert property (
    reg_rd && reg_addr > 4'h8 |=> reg_rdata_q == '0)
    else $error("unmapped read not zero");

  // main scenarios
  cov_restart: cover property (wr0);
  cov_switch_c_open: cover property ($fell(filter_switch_c));
  cov_power_down: cover property ($rose(ref_shunt_q));
endmodule : pll_ctrl_asserts

bind fracn_pll_ctrl pll_ctrl_asserts u_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .ref_series_a_q(ref_series_a_q), .ref_series_b_q(ref_series_b_q),
  .ref_shunt_q(ref_shunt_q), .pump_cells_en(pump_cells_en),
  .filter_switch_a(filter_switch_a), .filter_switch_b(filter_switch_b),
  .filter_switch_c(filter_switch_c), .lock_detect_q(lock_detect_q)
);

// *** bench/tb_fracn_pll_ctrl.sv ***
`timescale 1ns/10ps
`include "pll_ctrl_defines.svh"

module tb_fracn_pll_ctrl
  import pll_ctrl_pkg::*;
;
  logic               sys_clk, rst_n, ref_in, rf_in;
  logic               ser_clk, ser_data, ser_load;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`DATA_W-1:0] reg_wdata, reg_rdata_q, rdv;
  logic               reg_wr, reg_rd, lock_detect_q;
  logic               ref_series_a_q, ref_series_b_q, ref_shunt_q;
  logic               pump_out_pos_q, pump_out_neg_q;
  logic [`CELLS-1:0]  pump_cells_en;
  logic               filter_switch_a, filter_switch_b, filter_switch_c;
  logic [9:0]         vco_half;
  logic [7:0]         rnd;
  int                 n_mismatch, n_tests, u0, d0, tmr;
  int                 n_up = 0;
  int                 n_dn = 0;
  time                t0, t1;

  // design and far-side oscillators
  fracn_pll_ctrl DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ref_in(ref_in), .rf_in(rf_in),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .ref_series_a_q(ref_series_a_q), .ref_series_b_q(ref_series_b_q),
    .ref_shunt_q(ref_shunt_q), .pump_out_pos_q(pump_out_pos_q),
    .pump_out_neg_q(pump_out_neg_q), .pump_cells_en(pump_cells_en),
    .filter_switch_a(filter_switch_a), .filter_switch_b(filter_switch_b),
    .filter_switch_c(filter_switch_c), .lock_detect_q(lock_detect_q)
  );
  vco_ref_model model (
    .vco_half(vco_half), .ref_out(ref_in), .rf_out(rf_in)
  );

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // up and down pulse cycle counts
  always @(negedge sys_clk) begin
    if (pump_out_pos_q === 1'b1) n_up++;
    if (pump_out_neg_q === 1'b1) n_dn++;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // timer tick spacing: four pfd periods, toggle on, r divide r
  function automatic int step_ns(input int r);
    return 4 * 2 * r * 2080;
  endfunction : step_ns

  // timer word: value, select, word index 4
  function automatic logic [31:0] tw(input int v, input int s);
    return 32'(v * 32 + s * 8 + 4);
  endfunction : tw

  function automatic logic [5:0] pins();
    return {ref_series_a_q, ref_series_b_q, ref_shunt_q, filter_switch_a,
            filter_switch_c, lock_detect_q};
  endfunction : pins

  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: return $countones(pump_cells_en);
      1: return {31'h0, filter_switch_a};
      default: return {31'h0, filter_switch_c};
    endcase
  endfunction : probe

  task automatic check(input logic [31:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
    @(posedge sys_clk);
  endtask : rd

  // serial word, msb first, every pin level held at least four cycles
  task automatic ser_word(input logic [23:0] w);
    for (int b = 23; b >= 0; b--) begin
      ser_data <= w[b];
      repeat (4) @(posedge sys_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ser_clk <= 1'b0;
    end
    ser_load <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ser_load <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : ser_word

  task automatic wait_val(input int sel, input int v, output time t);
    int k;
    k = 0;
    while (probe(sel) !== 32'(v) && k < 20000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(k < 20000, 1'b1, "wait limit");
    t = $time;
  endtask : wait_val

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // hang guard
  initial begin
    #1500000;
    n_mismatch++;
    finish_test();
  end

  // test sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
    vco_half = 10'd100;
    rnd = 8'd40;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(pins(), 6'b110000, "reset pins");
    check(probe(0), 1, "reset cells");
    wr(4'h5, 32'h85);
    rd(4'h8, rdv);
    check(pins(), 6'b001000, "power down");
    check(rdv[3], 1'b1, "status shunt");
    wr(4'h5, 32'h5);
    rd(4'h8, rdv);
    check(pins(), 6'b110000, "power up");
    $display("test power done");
    // ignored writes and unmapped reads, random data
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr({1'b1, rnd[2:0]}, {24'h0, rnd});
      rd({1'b1, rnd[5:3] | 3'h1}, rdv);
      check(rdv, '0, "unmapped read");
    end
    check(probe(0), 1, "ignored write");
    $display("test refusal done");
    ser_word(24'h408009);
    rd(4'h1, rdv);
    check(rdv, 32'h408009, "serial word");
    wr(4'h0, 32'h0d0000);
    // slow vco lags, fast vco leads
    for (int f = 0; f < 2; f++) begin
      vco_half = f ? 10'd75 : 10'd100;
      repeat (2000) @(posedge sys_clk);
      u0 = n_up;
      d0 = n_dn;
      repeat (1000) @(posedge sys_clk);
      check((n_up - u0 > n_dn - d0) == (f == 0), 1'b1, "pump sign");
    end
    $display("test pump direction done");
    rnd = lfsr(rnd);
    tmr = 2 + rnd[1:0];
    wr(4'h4, tw(tmr, 0));
    wr(4'h4, tw(tmr + 7, 1));
    wr(4'h4, tw(tmr + 9, 2));
    wr(4'h0, 32'h0d0000);
    repeat (2) @(posedge sys_clk);
    #1;
    check(probe(0), 64, "all cells");
    check(pins(), 6'b110110, "wide switches");
    rd(4'h8, rdv);
    check(rdv[7:6], PH_WIDE, "wide phase");
    wait_val(0, 32, t0);
    for (int k = 4; k >= 0; k--) begin
      wait_val(0, 1 << k, t1);
      check(t1 - t0, step_ns(1), "ramp spacing");
      t0 = t1;
    end
    wait_val(1, 0, t1);
    check(t1 - t0, step_ns(1), "switch ab open");
    wait_val(2, 0, t0);
    check(t0 - t1, 2 * step_ns(1), "switch c open");
    $display("test fast lock done");
    rd(4'h8, rdv);
    check(rdv[7:4], {PH_NARROW, 2'b00}, "narrow");
    repeat (2000) @(posedge sys_clk);
    #1;
    check(probe(0), 1, "narrow hold");
    $display("test hold done");
    finish_test();
  end
endmodule : tb_fracn_pll_ctrl
